// File: core/bsf_seq_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module bsf_seq_top #(
  parameter int INRUSH_TICKS     = bsf_pkg::INRUSH_TICKS,
  parameter int SUPPLY_EN_TICKS  = bsf_pkg::SUPPLY_EN_TICKS,
  parameter int SOFT_BOOST_TICKS = bsf_pkg::SOFT_BOOST_TICKS,
  parameter int OSC_DIV          = bsf_pkg::OSC_DIV_CYC
) (
  input  wire logic                          CLK_I,
  input  wire logic                          SYS_RST_I,
  input  wire logic                          CE_I,
  input  wire logic                          CHIP_ENABLE_LOW_I,
  input  wire logic                          VOLTAGE_SELECT_I,
  input  wire logic                          SYNC_CLOCK_IN_I,
  input  wire bsf_pkg::bsf_sense_t           SENSE_I,
  output bsf_pkg::bsf_drive_t                DRIVE_O,
  output logic                               SWITCH_NODE_GATE_O,
  input  wire logic [bsf_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [bsf_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY
);

  localparam int ADDR_W = bsf_pkg::AXI_ADDR_W;
  localparam int DUR_W  = 16;
  localparam int TICK_W = 8;
  localparam int PER_W  = 8;

  typedef struct packed {
    logic                en_m;
    logic                en_s;
    logic                sel_m;
    logic                sel_s;
    logic                sync_m;
    logic                sync_s;
    bsf_pkg::bsf_sense_t sen_m;
    bsf_pkg::bsf_sense_t sen_s;
    bsf_pkg::bsf_state_t state;
    logic [TICK_W-1:0]   tick_cnt;
    logic [DUR_W-1:0]    dur;
    logic [15:0]         restarts;
    logic                sync_en;
    logic                restart_req;
    bsf_pkg::bsf_drive_t drv;
    logic                aw_full;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_full;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } bsf_top_st_t;

  bsf_top_st_t       r_reg;
  bsf_top_st_t       r_next;
  logic              osc_tick;
  logic              run;
  logic              sw_gate;
  logic              sync_locked;
  logic [PER_W-1:0]  sync_period;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_active(input bsf_pkg::bsf_state_t s);
    return s inside {bsf_pkg::ST_INRUSH, bsf_pkg::ST_SUPPLY_EN,
                     bsf_pkg::ST_SB25, bsf_pkg::ST_SB50,
                     bsf_pkg::ST_SB75, bsf_pkg::ST_NORMAL};
  endfunction : is_active

  function automatic bsf_pkg::bsf_state_t succ(input bsf_pkg::bsf_state_t s);
    case (s)
      bsf_pkg::ST_INRUSH:    return bsf_pkg::ST_SUPPLY_EN;
      bsf_pkg::ST_SUPPLY_EN: return bsf_pkg::ST_SB25;
      bsf_pkg::ST_SB25:      return bsf_pkg::ST_SB50;
      bsf_pkg::ST_SB50:      return bsf_pkg::ST_SB75;
      bsf_pkg::ST_SB75:      return bsf_pkg::ST_NORMAL;
      default:               return s;
    endcase
  endfunction : succ

  function automatic logic [DUR_W-1:0] dwell(input bsf_pkg::bsf_state_t s);
    case (s)
      bsf_pkg::ST_INRUSH:    return DUR_W'(INRUSH_TICKS);
      bsf_pkg::ST_SUPPLY_EN: return DUR_W'(SUPPLY_EN_TICKS);
      default:               return DUR_W'(SOFT_BOOST_TICKS);
    endcase
  endfunction : dwell

  function automatic bsf_pkg::bsf_drive_t drive_of(
    input bsf_pkg::bsf_state_t s,
    input logic                sel
  );
    bsf_pkg::bsf_drive_t d;
    d = '0;
    if (s != bsf_pkg::ST_OFF && s != bsf_pkg::ST_UV_WAIT) begin
      d.io_active = 1'b1;
      d.fb0_sense = ~sel;
      d.fb1_gnd   = ~sel;
      d.fb1_sense = sel;
      d.fb0_gnd   = sel;
    end
    d.inrush_src   = (s == bsf_pkg::ST_INRUSH);
    // Disconnect switch opens in every inactive state and in inrush
    d.supply_sw_on = is_active(s) && s != bsf_pkg::ST_INRUSH;
    case (s)
      bsf_pkg::ST_SB25:   d.ilim_pct = bsf_pkg::ILIM_25;
      bsf_pkg::ST_SB50:   d.ilim_pct = bsf_pkg::ILIM_50;
      bsf_pkg::ST_SB75:   d.ilim_pct = bsf_pkg::ILIM_75;
      bsf_pkg::ST_NORMAL: d.ilim_pct = bsf_pkg::ILIM_100;
      default:            d.ilim_pct = bsf_pkg::ILIM_OFF;
    endcase
    return d;
  endfunction : drive_of

  ////////////////////////////////////////////////////////////////////////////
  // Ready handshakes stall while the clock enable freezes the state; BVALID and RVALID are not gated
  assign S_AXI_AWREADY = CE_I & ~r_reg.aw_full;
  assign S_AXI_WREADY  = CE_I & ~r_reg.w_full;
  assign S_AXI_ARREADY = CE_I & ~r_reg.rvalid;
  assign S_AXI_BVALID  = r_reg.bvalid;
  assign S_AXI_BRESP   = r_reg.bresp;
  assign S_AXI_RVALID  = r_reg.rvalid;
  assign S_AXI_RDATA   = r_reg.rdata;
  assign S_AXI_RRESP   = r_reg.rresp;
  assign DRIVE_O            = r_reg.drv;
  assign SWITCH_NODE_GATE_O = sw_gate;

  assign osc_tick = (r_reg.tick_cnt == TICK_W'(OSC_DIV - 1));
  // Gate is cut one edge after any fault, on the same edge as the state change
  assign run = r_reg.state inside {bsf_pkg::ST_SB25, bsf_pkg::ST_SB50,
                                   bsf_pkg::ST_SB75, bsf_pkg::ST_NORMAL}
               & ~r_reg.en_s & ~r_reg.sen_s.uv & ~r_reg.sen_s.oc
               & ~r_reg.sen_s.ov & ~r_reg.sen_s.ot;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.en_m   = CHIP_ENABLE_LOW_I;
    r_next.en_s   = r_reg.en_m;
    r_next.sel_m  = VOLTAGE_SELECT_I;
    r_next.sel_s  = r_reg.sel_m;
    r_next.sync_m = SYNC_CLOCK_IN_I;
    r_next.sync_s = r_reg.sync_m;
    r_next.sen_m  = SENSE_I;
    r_next.sen_s  = r_reg.sen_m;
    r_next.tick_cnt    = osc_tick ? '0 : r_reg.tick_cnt + 1'b1;
    r_next.restart_req = 1'b0;

    // Register bus
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      r_next.w_full = 1'b1;
      r_next.w_data = S_AXI_WDATA;
      r_next.w_strb = S_AXI_WSTRB;
    end
    if (r_reg.bvalid && S_AXI_BREADY) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = bsf_pkg::RESP_OKAY;
      case (r_reg.aw_addr)
        bsf_pkg::REG_CTRL: begin
          if (r_reg.w_strb[0]) begin
            r_next.sync_en     = r_reg.w_data[bsf_pkg::CTRL_SYNC_EN_BIT];
            r_next.restart_req = r_reg.w_data[bsf_pkg::CTRL_RESTART_BIT];
          end
        end
        bsf_pkg::REG_STATUS, bsf_pkg::REG_RESTARTS,
        bsf_pkg::REG_SYNC_PER: begin
        end
        default: r_next.bresp = bsf_pkg::RESP_SLVERR;
      endcase
    end
    if (r_reg.rvalid && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = '0;
      r_next.rresp  = bsf_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        bsf_pkg::REG_CTRL:
          r_next.rdata[bsf_pkg::CTRL_SYNC_EN_BIT] = r_reg.sync_en;
        bsf_pkg::REG_STATUS: begin
          r_next.rdata[bsf_pkg::STS_STATE_LSB +: 4] = r_reg.state;
          r_next.rdata[bsf_pkg::STS_UV_BIT]   = r_reg.sen_s.uv;
          r_next.rdata[bsf_pkg::STS_OC_BIT]   = r_reg.sen_s.oc;
          r_next.rdata[bsf_pkg::STS_OV_BIT]   = r_reg.sen_s.ov;
          r_next.rdata[bsf_pkg::STS_OT_BIT]   = r_reg.sen_s.ot;
          r_next.rdata[bsf_pkg::STS_LOCK_BIT] = sync_locked;
          r_next.rdata[bsf_pkg::STS_OFF_BIT]  = r_reg.en_s;
          r_next.rdata[bsf_pkg::STS_ILIM_LSB +: 7] = r_reg.drv.ilim_pct;
        end
        bsf_pkg::REG_RESTARTS: r_next.rdata[15:0] = r_reg.restarts;
        bsf_pkg::REG_SYNC_PER: r_next.rdata[PER_W-1:0] = sync_period;
        default: r_next.rresp = bsf_pkg::RESP_SLVERR;
      endcase
    end

    // Sequencer: disable, then undervoltage, then hold faults, then restarts
    if (r_reg.en_s) begin
      r_next.state = bsf_pkg::ST_OFF;
      r_next.dur   = '0;
    end else if (r_reg.sen_s.uv) begin
      r_next.state = bsf_pkg::ST_UV_WAIT;
      r_next.dur   = '0;
    end else if (r_reg.sen_s.ov || r_reg.sen_s.ot) begin
      r_next.state = bsf_pkg::ST_FAULT_HOLD;
      r_next.dur   = '0;
    end else if (is_active(r_reg.state)
                 && (r_reg.sen_s.oc || r_reg.restart_req)) begin
      r_next.state    = bsf_pkg::ST_INRUSH;
      r_next.dur      = '0;
      r_next.restarts = r_reg.restarts + 1'b1;
    end else begin
      case (r_reg.state)
        bsf_pkg::ST_OFF: begin
          r_next.state = bsf_pkg::ST_INRUSH;
        end
        bsf_pkg::ST_UV_WAIT, bsf_pkg::ST_FAULT_HOLD: begin
          // Comparators carry the hysteresis, so a clear flag means recovered
          r_next.state    = bsf_pkg::ST_INRUSH;
          r_next.restarts = r_reg.restarts + 1'b1;
        end
        bsf_pkg::ST_NORMAL: begin
          r_next.state = bsf_pkg::ST_NORMAL;
        end
        default: begin
          if (osc_tick) begin
            if (r_reg.dur == dwell(r_reg.state) - 1'b1) begin
              r_next.state = succ(r_reg.state);
              r_next.dur   = '0;
            end else begin
              r_next.dur = r_reg.dur + 1'b1;
            end
          end
        end
      endcase
    end
    r_next.drv = drive_of(r_next.state, r_reg.sel_s);
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      r_reg         <= '0;
      r_reg.en_m    <= 1'b1;
      r_reg.en_s    <= 1'b1;
      r_reg.sync_m  <= 1'b1;
      r_reg.sync_s  <= 1'b1;
      r_reg.sync_en <= bsf_pkg::CTRL_SYNC_EN_RST;
    end else if (CE_I) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  bsf_switch_ctl #(
    .OSC_DIV (OSC_DIV),
    .CNT_W   (PER_W)
  ) u_switch (
    .clk_i         (CLK_I),
    .rst_i         (SYS_RST_I),
    .ce_i          (CE_I),
    .osc_tick_i    (osc_tick),
    .sync_n_i      (r_reg.sync_s),
    .sync_allow_i  (r_reg.sync_en),
    .run_i         (run),
    .fb_above_i    (r_reg.sen_s.fb_above),
    .peak_hit_i    (r_reg.sen_s.peak_hit),
    .gate_on_o     (sw_gate),
    .sync_locked_o (sync_locked),
    .sync_period_o (sync_period)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic fault_any;
  assign fault_any = r_reg.sen_s.uv | r_reg.sen_s.oc | r_reg.sen_s.ov
                     | r_reg.sen_s.ot;

  a_disabled_all_off: assert property (CE_I && r_reg.en_s |=>
      !DRIVE_O.io_active && !DRIVE_O.supply_sw_on && !sw_gate)
    else $error("outputs active while disabled");
  a_switch_open_off: assert property (r_reg.state == bsf_pkg::ST_OFF
      |-> !DRIVE_O.supply_sw_on && !DRIVE_O.inrush_src)
    else $error("disconnect switch closed while off");
  a_enable_starts: assert property (CE_I && !r_reg.en_s && !fault_any
      && r_reg.state == bsf_pkg::ST_OFF |=> r_reg.state == bsf_pkg::ST_INRUSH)
    else $error("enable did not start sequence");
  a_order_fixed: assert property (CE_I && is_active(r_reg.state)
      && is_active(r_next.state) && r_next.state != r_reg.state
      |-> r_next.state == succ(r_reg.state)
          || r_next.state == bsf_pkg::ST_INRUSH)
    else $error("sequence step out of order");
  a_normal_holds: assert property (CE_I && !r_reg.en_s
      && r_reg.state == bsf_pkg::ST_NORMAL && !fault_any && !r_reg.restart_req
      |=> r_reg.state == bsf_pkg::ST_NORMAL)
    else $error("left normal without cause");
  a_inrush_length: assert property (r_reg.state == bsf_pkg::ST_INRUSH
      && r_next.state == bsf_pkg::ST_SUPPLY_EN && CE_I
      |-> osc_tick && r_reg.dur == DUR_W'(INRUSH_TICKS - 1))
    else $error("inrush length wrong");
  a_ilim_steps: assert property (r_reg.state == bsf_pkg::ST_SB50
      |-> DRIVE_O.ilim_pct == bsf_pkg::ILIM_50 && DRIVE_O.supply_sw_on)
    else $error("current limit step wrong");
  a_gate_waits: assert property (CE_I && !(r_reg.state inside
      {bsf_pkg::ST_SB25, bsf_pkg::ST_SB50, bsf_pkg::ST_SB75,
       bsf_pkg::ST_NORMAL}) |=> !sw_gate)
    else $error("switching outside boost states");
  a_overvolt_stop: assert property (CE_I && r_reg.sen_s.ov
      && !r_reg.en_s && !r_reg.sen_s.uv
      |=> !sw_gate && r_reg.state == bsf_pkg::ST_FAULT_HOLD)
    else $error("overvoltage did not stop boost");
  a_fb_roles: assert property (DRIVE_O.io_active
      |-> DRIVE_O.fb0_sense == DRIVE_O.fb1_gnd
          && DRIVE_O.fb0_sense != DRIVE_O.fb0_gnd)
    else $error("feedback pin roles inconsistent");

  c_reach_normal: cover property (r_reg.state == bsf_pkg::ST_SB75
      ##1 r_reg.state == bsf_pkg::ST_NORMAL);
  c_oc_restart: cover property (r_reg.state == bsf_pkg::ST_NORMAL
      && r_reg.sen_s.oc ##1 r_reg.state == bsf_pkg::ST_INRUSH);
  c_sync_lock: cover property (sync_locked && sw_gate);
  c_fault_hold: cover property (r_reg.state == bsf_pkg::ST_FAULT_HOLD
      ##1 r_reg.state == bsf_pkg::ST_INRUSH);

endmodule : bsf_seq_top

// File: core/bsf_pkg.sv
package bsf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int OSC_FREQ_KHZ     = 1000;
  localparam int OSC_PERIOD_NS    = 1000000 / OSC_FREQ_KHZ;
  localparam int OSC_DIV_CYC      = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int INRUSH_US        = 2048;
  localparam int SUPPLY_EN_US     = 128;
  localparam int SOFT_BOOST_US    = 2048;
  localparam int INRUSH_TICKS     = INRUSH_US * 1000 / OSC_PERIOD_NS;
  localparam int SUPPLY_EN_TICKS  = SUPPLY_EN_US * 1000 / OSC_PERIOD_NS;
  localparam int SOFT_BOOST_TICKS = SOFT_BOOST_US * 1000 / OSC_PERIOD_NS;
  // Longest gap between sync falls still counted as a live clock
  localparam int SYNC_DET_KHZ     = 300;
  localparam int SYNC_MAX_GAP_CYC = 1000000 / SYNC_DET_KHZ / CLK_PERIOD_NS;
  localparam int MIN_OFF_NS       = 100;
  localparam int MIN_OFF_CYC      = (MIN_OFF_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Current limit steps, percent of final value
  localparam logic [6:0] ILIM_OFF = 7'h00;
  localparam logic [6:0] ILIM_25  = 7'h19;
  localparam logic [6:0] ILIM_50  = 7'h32;
  localparam logic [6:0] ILIM_75  = 7'h4b;
  localparam logic [6:0] ILIM_100 = 7'h64;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          AXI_ADDR_W       = 4;
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h4;
  localparam logic [3:0]  REG_RESTARTS     = 4'h8;
  localparam logic [3:0]  REG_SYNC_PER     = 4'hc;
  localparam int          CTRL_RESTART_BIT = 0;
  localparam int          CTRL_SYNC_EN_BIT = 1;
  localparam logic        CTRL_SYNC_EN_RST = 1'b1;
  localparam int          STS_STATE_LSB    = 0;
  localparam int          STS_UV_BIT       = 4;
  localparam int          STS_OC_BIT       = 5;
  localparam int          STS_OV_BIT       = 6;
  localparam int          STS_OT_BIT       = 7;
  localparam int          STS_LOCK_BIT     = 8;
  localparam int          STS_OFF_BIT      = 9;
  localparam int          STS_ILIM_LSB     = 16;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_OFF, ST_UV_WAIT, ST_FAULT_HOLD, ST_INRUSH, ST_SUPPLY_EN,
    ST_SB25, ST_SB50, ST_SB75, ST_NORMAL
  } bsf_state_t;

  typedef struct packed {
    logic uv;
    logic oc;
    logic ov;
    logic ot;
    logic fb_above;
    logic peak_hit;
  } bsf_sense_t;

  typedef struct packed {
    logic       io_active;
    logic       inrush_src;
    logic       supply_sw_on;
    logic       fb0_sense;
    logic       fb1_sense;
    logic       fb0_gnd;
    logic       fb1_gnd;
    logic [6:0] ilim_pct;
  } bsf_drive_t;

endpackage : bsf_pkg

// File: core/bsf_switch_ctl.sv
`timescale 1ns/10ps
module bsf_switch_ctl #(
  parameter int OSC_DIV = bsf_pkg::OSC_DIV_CYC,
  parameter int CNT_W   = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             osc_tick_i,
  input  wire logic             sync_n_i,
  input  wire logic             sync_allow_i,
  input  wire logic             run_i,
  input  wire logic             fb_above_i,
  input  wire logic             peak_hit_i,
  output logic                  gate_on_o,
  output logic                  sync_locked_o,
  output logic [CNT_W-1:0]      sync_period_o
);

  typedef struct packed {
    logic             sync_prev;
    logic [CNT_W-1:0] gap_cnt;
    logic [CNT_W-1:0] period;
    logic             locked;
    logic             gate;
    logic [CNT_W-1:0] on_cnt;
  } bsf_sw_st_t;

  localparam logic [CNT_W-1:0] GAP_MAX = CNT_W'(bsf_pkg::SYNC_MAX_GAP_CYC);
  localparam logic [CNT_W-1:0] MIN_OFF = CNT_W'(bsf_pkg::MIN_OFF_CYC);
  localparam logic [CNT_W-1:0] INT_PER = CNT_W'(OSC_DIV);

  bsf_sw_st_t       r_reg;
  bsf_sw_st_t       r_next;
  logic             sync_fall;
  logic             use_ext;
  logic             start;
  logic [CNT_W-1:0] per_len;
  logic [CNT_W-1:0] off_at;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next    = r_reg;
    sync_fall = r_reg.sync_prev & ~sync_n_i;
    r_next.sync_prev = sync_n_i;
    // Lock only while consecutive falls come faster than the detect limit
    if (sync_fall) begin
      r_next.locked  = (r_reg.gap_cnt < GAP_MAX);
      r_next.period  = r_reg.gap_cnt + 1'b1;
      r_next.gap_cnt = '0;
    end else begin
      if (r_reg.gap_cnt != '1) begin
        r_next.gap_cnt = r_reg.gap_cnt + 1'b1;
      end
      if (r_reg.gap_cnt >= GAP_MAX) begin
        r_next.locked = 1'b0;
      end
    end
    use_ext = r_reg.locked & sync_allow_i;
    // Period start is the gate turning on, i.e. the switch node falling
    start   = use_ext ? sync_fall : osc_tick_i;
    per_len = use_ext ? r_reg.period : INT_PER;
    // Off time is reserved at the end of every period
    off_at  = (per_len > MIN_OFF) ? per_len - MIN_OFF : CNT_W'(1);
    if (!run_i) begin
      r_next.gate = 1'b0;
    end else if (start) begin
      r_next.gate   = ~fb_above_i;
      r_next.on_cnt = CNT_W'(1);
    end else if (r_reg.gate) begin
      if (peak_hit_i || r_reg.on_cnt >= off_at) begin
        r_next.gate = 1'b0;
      end else begin
        r_next.on_cnt = r_reg.on_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign gate_on_o     = r_reg.gate;
  assign sync_locked_o = r_reg.locked;
  assign sync_period_o = r_reg.period;

endmodule : bsf_switch_ctl

// File: bench/bsf_host_model.sv
`timescale 1ns/10ps
module bsf_host_model (
  input  wire logic run_i,
  output logic      sync_o
);
  // Sync stays static high outside use, so the part falls back to its osc
  initial begin
    sync_o = 1'b1;
    forever begin
      #500;
      sync_o = run_i ? ~sync_o : 1'b1;
    end
  end
endmodule : bsf_host_model

// File: bench/bsf_seq_top_tb.sv
`timescale 1ns/10ps
module bsf_seq_top_tb;
  logic                clk, rst, chip_enable_low, sel, run, sync, gate, ce;
  logic                awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [3:0]          awa, ara, ws;
  logic [31:0]         wd, rd;
  logic [1:0]          bresp, rresp;
  logic [15:0]         lf;
  bsf_pkg::bsf_sense_t sense;
  bsf_pkg::bsf_drive_t drv;
  int                  errors, comparisons;
  bsf_seq_top #(.INRUSH_TICKS(8), .SUPPLY_EN_TICKS(4),
    .SOFT_BOOST_TICKS(8), .OSC_DIV(4)) u_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .CHIP_ENABLE_LOW_I(chip_enable_low),
    .VOLTAGE_SELECT_I(sel), .SYNC_CLOCK_IN_I(sync), .SENSE_I(sense),
    .DRIVE_O(drv), .SWITCH_NODE_GATE_O(gate),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
  bsf_host_model u_host (.run_i(run), .sync_o(sync));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic logic [3:0] fbx(input logic s);
    return {~s, s, s, ~s};
  endfunction : fbx
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic wait_ilim(input logic [6:0] v);
    for (int n = 0; n < 400 && drv.ilim_pct !== v; n++) @(posedge clk);
    #1 chk("ilim", 32'(v), 32'(drv.ilim_pct));
  endtask : wait_ilim
  // Peak trips are random so the gate sees both turn-off causes
  task automatic gate_cnt(output int c);
    c = 0;
    repeat (20) begin
      @(posedge clk);
      lf = nxt(lf);
      sense.peak_hit <= lf[0];
      c += int'(gate === 1'b1);
    end
  endtask : gate_cnt
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    br <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rd;
    r = rresp;
    rr <= 1'b0;
  endtask : axr
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #500000;
    errors++;
    stop_test();
  end
  initial begin
    int c;
    logic [31:0] d;
    logic [1:0] r;
    rst = 1; chip_enable_low = 1; sel = 0; run = 0; sense = '0; ce = 1; ws = 4'hf;
    {awv, wv, br, arv, rr} = '0; awa = '0; ara = '0; wd = '0;
    lf = 16'hcbc2; errors = 0; comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("off", 0, {drv, gate});
    lf = nxt(lf);
    sel <= lf[0];
    chip_enable_low <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("inrush", 1, drv.inrush_src);
    wait_ilim(bsf_pkg::ILIM_25);
    gate_cnt(c);
    chk("switching", 1, c > 0);
    wait_ilim(bsf_pkg::ILIM_50);
    wait_ilim(bsf_pkg::ILIM_75);
    wait_ilim(bsf_pkg::ILIM_100);
    chk("fb", fbx(sel), {drv.fb0_sense, drv.fb1_sense,
        drv.fb0_gnd, drv.fb1_gnd});
    sense.fb_above <= 1'b1;
    repeat (8) @(posedge clk);
    gate_cnt(c);
    chk("skip", 0, c);
    sense.fb_above <= 1'b0;
    run <= 1'b1;
    repeat (80) @(posedge clk);
    axr(bsf_pkg::REG_STATUS, d, r);
    chk("state", 8, d[3:0]);
    chk("lock", 1, d[8]);
    axw(bsf_pkg::REG_CTRL, 1, r);
    chk("bresp", bsf_pkg::RESP_OKAY, r);
    axr(bsf_pkg::REG_RESTARTS, d, r);
    chk("restarts", 1, d);
    axr(4'h2, d, r);
    chk("unmapped", bsf_pkg::RESP_SLVERR, r);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 5 : (i == 1) ? 3 : 2;
      sense[c] <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("stop", {c != 5, 2'b0}, {drv.io_active, drv.supply_sw_on,
          gate});
      sense[c] <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("restart", 1, drv.inrush_src);
    end
    wait_ilim(bsf_pkg::ILIM_25);
    sense.oc <= 1'b1;
    @(posedge clk);
    sense.oc <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("oc", 3'b110, {drv.inrush_src, drv.ilim_pct == 0, gate});
    ce <= 1'b0;
    chip_enable_low <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("freeze", 1, drv.inrush_src);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("off", 0, {drv, gate});
    stop_test();
  end
endmodule : bsf_seq_top_tb
